// >>> core/ddri_ctrl.sv
`timescale 1ns/1ps
`include "ddri_map.svh"
// Summary of operation
// (RQ1) Refreshes are never postponed by more than eight intervals.
// (RQ2) Clock enable stays high from every refresh to its cycle end.
// (RQ3) Auto-precharge reads and writes wait until row-active time is met.
// (RQ4) A clock rate change resets the DLL and holds reads 200 cycles.
// (RQ5) At power-up clock enable is low with a running clock for 200 us.
// (RQ6) Clock enable then rises together with a no-operation command.
// (RQ7) A first precharge-all is followed by the precharge period of idle.
// (RQ8) The extended mode register enables the DLL and sets drive strength.
// (RQ9) Every mode load is followed by the mode-set delay of idle.
// (RQ10) The base mode load resets the DLL; reads wait 200 cycles after.
// (RQ11) A second precharge-all follows, with the precharge period of idle.
// (RQ12) Two auto refreshes follow, each with the refresh cycle of idle.
// (RQ13) A last mode load clears the DLL reset with the same parameters.
// (RQ14) Each byte lane has its own data strobe, used for that lane only.
// (RQ15) Refreshes are at most 140.6 us or 70.3 us apart, by density.
// (RQ16) Refreshes average one per 15.625 us or 7.8125 us, by density; the code spaces them 977 or 489 link cycles, 15.632 us or 7.824 us.
// (RQ17) Every wait becomes a cycle count rounded up to meet its minimum.
module ddri_ctrl #(
   parameter logic [`DDRI_TW-1:0] P_N_PWR    = `DDRI_TW'(`DDRI_N_PWR),
   parameter logic [`DDRI_TW-1:0] P_N_REFC_S = `DDRI_TW'(`DDRI_N_REFC_S),
   parameter logic [`DDRI_TW-1:0] P_N_REFC_L = `DDRI_TW'(`DDRI_N_REFC_L)
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   ce,
   input  wire logic                   usr_freq_chg,
   input  wire logic                   usr_drv_reduced,
   input  wire logic                   usr_dense,
   input  wire logic [7:0]             usr_mode,
   input  wire logic                   usr_hold_ref,
   input  wire logic                   usr_valid,
   output logic                        usr_ready,
   input  wire ddri_pkg::ddri_cmd_t    usr_cmd,
   input  wire logic [1:0]             usr_ba,
   input  wire logic [`DDRI_AW-1:0]    usr_addr,
   input  wire logic [`DDRI_LANES-1:0] usr_lanes,
   output logic                        init_done,
   output logic                        read_ok,
   output logic [3:0]                  ref_owed,
   output logic                        ddr_ck,
   output logic                        ddr_ck_n,
   output logic                        ddr_cke,
   output logic                        ddr_cs_n,
   output logic                        ddr_ras_n,
   output logic                        ddr_cas_n,
   output logic                        ddr_we_n,
   output logic [1:0]                  ddr_ba,
   output logic [`DDRI_AW-1:0]         ddr_addr,
   output logic [`DDRI_LANES-1:0]      ddr_dqs_oe
);
   import ddri_pkg::*;
   // ************************************************************
   // cycle counts of the link clock
   // ************************************************************
   localparam logic [`DDRI_TW-1:0] N_RP  = `DDRI_TW'(`DDRI_N_RP);  // RQ17
   localparam logic [`DDRI_TW-1:0] N_RFC = `DDRI_TW'(`DDRI_N_RFC); // RQ17
   localparam logic [`DDRI_TW-1:0] N_MRD = `DDRI_TW'(`DDRI_N_MRD); // RQ17
   localparam logic [`DDRI_TW-1:0] N_RAS = `DDRI_TW'(`DDRI_N_RAS); // RQ17
   localparam logic [`DDRI_TW-1:0] N_REFI_S = `DDRI_TW'(`DDRI_N_REFI_S);
   localparam logic [`DDRI_TW-1:0] N_REFI_L = `DDRI_TW'(`DDRI_N_REFI_L);

   ddri_if      bus ();
   ddri_state_t st_q;
   ddri_state_t st_d;
   ddri_cmd_t   cmd_q;
   ddri_cmd_t   cmd_d;
   logic [1:0]  ba_q;
   logic [1:0]  ba_d;
   logic [`DDRI_AW-1:0] addr_q;
   logic [`DDRI_AW-1:0] addr_d;
   logic [`DDRI_LANES-1:0] lanes_q;
   logic        cke_q;
   logic        pwr_q;
   logic        init_q;
   logic        freq_q;
   logic [3:0]  owed_q;
   logic [`DDRI_TW-1:0] refi_q;
   logic [`DDRI_TW-1:0] gap_q;
   logic [7:0]  dll_q;
   logic [`DDRI_TW-1:0] ras_q;
   logic        tmr_ld;
   logic [`DDRI_TW-1:0] ld_val;
   logic        tmr_done;
   logic        step;
   logic        refi_hit;
   logic        ref_must;
   logic        ref_go;
   logic        usr_legal;
   logic        is_ap;

   // ************************************************************
   // leaf blocks
   // ************************************************************
   ddri_link u_link (
      .clk        (clk),
      .rst_n      (rst_n),
      .ce         (ce),
      .bus        (bus.link),
      .ddr_ck     (ddr_ck),
      .ddr_ck_n   (ddr_ck_n),
      .ddr_cke    (ddr_cke),
      .ddr_cs_n   (ddr_cs_n),
      .ddr_ras_n  (ddr_ras_n),
      .ddr_cas_n  (ddr_cas_n),
      .ddr_we_n   (ddr_we_n),
      .ddr_ba     (ddr_ba),
      .ddr_addr   (ddr_addr),
      .ddr_dqs_oe (ddr_dqs_oe)
   );

   ddri_timer u_tmr (
      .clk   (clk),
      .rst_n (rst_n),
      .tick  (bus.tick),
      .ld    (tmr_ld),
      .val   (ld_val),
      .done  (tmr_done)
   );

   assign bus.cmd   = cmd_q;
   assign bus.ba    = ba_q;
   assign bus.addr  = addr_q;
   assign bus.cke   = cke_q;
   assign bus.lanes = lanes_q;
   assign step      = bus.tick & tmr_done;

   // ************************************************************
   // refresh bookkeeping
   // ************************************************************
   // a slack keeps the forced refresh inside the gap limit even after
   // a precharge-all has to go first
   assign refi_hit = init_q &
                     (refi_q >= (usr_dense ? N_REFI_L : N_REFI_S)); // RQ16
   assign ref_must = (owed_q >= `DDRI_POST_MAX) |                   // RQ1
                     (gap_q >= ((usr_dense ? P_N_REFC_L : P_N_REFC_S)
                                - `DDRI_REF_GUARD));                 // RQ15
   assign ref_go   = ref_must | ((owed_q != 4'h0) & ~usr_hold_ref);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refi_q <= '0;
      end else if (bus.tick) begin
         refi_q <= refi_hit ? '0 : refi_q + `DDRI_TW'(1);           // RQ16
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         owed_q <= 4'h0;
      end else if (bus.tick) begin
         if (!init_q) begin
            owed_q <= 4'h0;
         end else if (refi_hit && !(step && st_q == ST_RREF)) begin
            if (owed_q < `DDRI_POST_MAX) begin
               owed_q <= owed_q + 4'h1;                               // RQ1
            end
         end else if (!refi_hit && step && st_q == ST_RREF) begin
            owed_q <= owed_q - 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q <= '0;
      end else if (bus.tick) begin
         if (cmd_d == CMD_REF || !init_q) begin
            gap_q <= '0;                                             // RQ15
         end else if (gap_q != '1) begin
            gap_q <= gap_q + `DDRI_TW'(1);
         end
      end
   end

   // ************************************************************
   // user command legality
   // ************************************************************
   assign is_ap = ((usr_cmd == CMD_RD) | (usr_cmd == CMD_WR)) &
                  usr_addr[`DDRI_A_AP];
   assign usr_legal = ~((usr_cmd == CMD_RD) & (dll_q != 8'h0)) &   // RQ4
                      ~(is_ap & (ras_q != '0)) &                     // RQ3
                      (usr_cmd != CMD_LMR);

   // ************************************************************
   // sequence
   // ************************************************************
   always_comb begin
      st_d      = st_q;
      cmd_d     = CMD_NOP;
      ba_d      = ba_q;
      addr_d    = addr_q;
      tmr_ld    = 1'b0;
      ld_val    = '0;
      usr_ready = 1'b0;
      if (step) begin
         case (st_q)
            ST_PWR: begin
               tmr_ld = 1'b1;                                        // RQ6
               ld_val = pwr_q ? '0 : P_N_PWR;                        // RQ5
               st_d   = pwr_q ? ST_PRE1 : ST_PWR;
            end
            ST_PRE1, ST_PRE2, ST_RPRE: begin
               cmd_d  = CMD_PRE;
               addr_d = '0;
               addr_d[`DDRI_A_AP] = 1'b1;
               tmr_ld = 1'b1;
               ld_val = N_RP;                                  // RQ7 RQ11
               st_d   = (st_q == ST_PRE1) ? ST_EMR :
                        (st_q == ST_PRE2) ? ST_REF1 : ST_RREF;
            end
            ST_EMR: begin
               cmd_d  = CMD_LMR;
               ba_d   = `DDRI_BA_EMR;
               addr_d = '0;
               addr_d[`DDRI_DLL_DIS] = 1'b0;                          // RQ8
               addr_d[`DDRI_DRV] = usr_drv_reduced;                   // RQ8
               tmr_ld = 1'b1;
               ld_val = N_MRD;                                        // RQ9
               st_d   = ST_MRS;
            end
            ST_MRS, ST_MRS2: begin
               cmd_d  = CMD_LMR;
               ba_d   = `DDRI_BA_MR;
               addr_d = {5'h00, usr_mode};                           // RQ13
               addr_d[`DDRI_DLL_RST] = (st_q == ST_MRS);       // RQ10 RQ13
               tmr_ld = 1'b1;
               ld_val = N_MRD;                                        // RQ9
               st_d   = (st_q == ST_MRS) ? ST_PRE2 : ST_IDLE;
            end
            ST_REF1, ST_REF2, ST_RREF: begin
               cmd_d  = CMD_REF;
               tmr_ld = 1'b1;
               ld_val = N_RFC;                                 // RQ2 RQ12
               st_d   = (st_q == ST_REF1) ? ST_REF2 :
                        (st_q == ST_REF2) ? ST_MRS2 : ST_IDLE;
            end
            ST_IDLE: begin
               if (freq_q) begin
                  st_d = ST_PRE1;                                     // RQ4
               end else if (ref_go) begin
                  st_d = ST_RPRE;
               end else begin
                  usr_ready = usr_legal;
                  if (usr_valid && usr_legal) begin
                     cmd_d  = usr_cmd;
                     ba_d   = usr_ba;
                     addr_d = usr_addr;
                  end
               end
            end
            default: begin
               st_d = ST_PWR;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q    <= ST_PWR;
         cmd_q   <= CMD_NOP;
         ba_q    <= '0;
         addr_q  <= '0;
         lanes_q <= '0;
      end else if (bus.tick) begin
         st_q    <= st_d;
         cmd_q   <= cmd_d;
         ba_q    <= ba_d;
         addr_q  <= addr_d;
         if (usr_valid && usr_ready) begin
            lanes_q <= usr_lanes;                                     // RQ14
         end
      end
   end

   // power-up wait is the timer's first load, taken out of reset
   // so it needs no strap; cke never drops once raised
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_q <= 1'b0;
         cke_q <= 1'b0;                                               // RQ5
      end else if (step && st_q == ST_PWR) begin
         pwr_q <= 1'b1;
         cke_q <= pwr_q;                                        // RQ2 RQ6
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         init_q <= 1'b0;
      end else if (step && st_q == ST_MRS2) begin
         init_q <= 1'b1;
      end else if (step && st_q == ST_IDLE && freq_q) begin
         init_q <= 1'b0;
      end
   end

   // set wins over the clear taken on leaving idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         freq_q <= 1'b0;
      end else if (ce && usr_freq_chg) begin
         freq_q <= 1'b1;
      end else if (step && st_q == ST_IDLE) begin
         freq_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dll_q <= `DDRI_DLL_CYC;
      end else if (bus.tick) begin
         if (step && st_q == ST_MRS) begin
            dll_q <= `DDRI_DLL_CYC;                            // RQ4 RQ10
         end else if (dll_q != 8'h0) begin
            dll_q <= dll_q - 8'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ras_q <= '0;
      end else if (bus.tick) begin
         if (cmd_d == CMD_ACT) begin
            ras_q <= N_RAS;                                           // RQ3
         end else if (ras_q != '0) begin
            ras_q <= ras_q - `DDRI_TW'(1);
         end
      end
   end

   assign init_done = init_q;
   assign read_ok   = init_q & (dll_q == 8'h0);
   assign ref_owed  = owed_q;

   // ************************************************************
   // checks
   // ************************************************************
   logic [`DDRI_TW-1:0] since_q;
   logic [`DDRI_TW-1:0] low_q;
   ddri_cmd_t           last_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         since_q <= '0;
         last_q  <= CMD_NOP;
         low_q   <= '0;
      end else if (bus.tick) begin
         if (cmd_q != CMD_NOP) begin
            since_q <= `DDRI_TW'(1);
            last_q  <= cmd_q;
         end else if (since_q != '1) begin
            since_q <= since_q + `DDRI_TW'(1);
         end
         if (!cke_q && low_q != '1) begin
            low_q <= low_q + `DDRI_TW'(1);
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_cmd_after(ddri_cmd_t c);
      bus.tick && cmd_q != CMD_NOP && last_q == c;
   endsequence

   sequence s_pwr_exit;
      $rose(cke_q) ##0 (cmd_q == CMD_NOP);
   endsequence

   chk_pwr_wait: assert property ($rose(cke_q) |-> low_q >= P_N_PWR) // RQ5
      else $error("clock enable raised before the power-up wait");
   chk_nop_first: assert property ($rose(cke_q) |-> s_pwr_exit) // RQ6
      else $error("first command with clock enable high is not a nop");
   chk_pre_idle: assert property (s_cmd_after(CMD_PRE) |->    // RQ7 RQ11
      since_q > N_RP)
      else $error("command too soon after precharge-all");
   chk_mrd_idle: assert property (s_cmd_after(CMD_LMR) |->    // RQ9
      since_q > N_MRD)
      else $error("command too soon after mode load");
   chk_rfc_idle: assert property (s_cmd_after(CMD_REF) |->    // RQ12
      since_q > N_RFC)
      else $error("command too soon after refresh");
   chk_emr_bits: assert property (bus.tick && cmd_q == CMD_LMR && // RQ8
      ba_q == `DDRI_BA_EMR |-> addr_q[`DDRI_DLL_DIS] == 1'b0 &&
      addr_q[`DDRI_AW-1:`DDRI_DRV+1] == '0)
      else $error("extended mode value malformed");
   chk_read_dll: assert property (bus.tick && cmd_q == CMD_RD |-> // RQ10
      dll_q == 8'h0 && init_q)
      else $error("read issued inside the dll lock window");
   chk_ap_tras: assert property (bus.tick && ras_q != '0 |-> // RQ3
      !(cmd_d inside {CMD_RD, CMD_WR} && addr_d[`DDRI_A_AP]))
      else $error("auto precharge before row-active time");
   chk_owed_max: assert property (owed_q <= `DDRI_POST_MAX) // RQ1
      else $error("refresh postponed beyond the limit");
   chk_cke_hold: assert property ($rose(cke_q) |=>            // RQ2
      cke_q [*8])
      else $error("clock enable dropped after power-up");
   chk_freq_dll: assert property (step && st_q == ST_IDLE &&  // RQ4
      freq_q |=> st_q == ST_PRE1 && !init_q)
      else $error("clock change did not restart the dll sequence");
endmodule : ddri_ctrl

// >>> core/ddri_map.svh
`ifndef DDRI_MAP_SVH
`define DDRI_MAP_SVH
// ************************************************************
// clock and link rate
// ************************************************************
`define DDRI_CLK_PS   8000
`define DDRI_CK_PS    (2 * `DDRI_CLK_PS)
`define DDRI_TW       14
// ************************************************************
// timing figures in their own units
// ************************************************************
`define DDRI_T_PWR_US   200
`define DDRI_T_RP_NS    15
`define DDRI_T_RFC_NS   70
`define DDRI_T_MRD_NS   10
`define DDRI_T_RAS_NS   40
`define DDRI_T_REFI_S_PS 15625000
`define DDRI_T_REFI_L_PS 7812500
`define DDRI_T_REFC_S_PS 140600000
`define DDRI_T_REFC_L_PS 70300000
// ************************************************************
// cycle counts: least times round up, longest times round down
// ************************************************************
`define DDRI_CEIL(ps) (((ps) + `DDRI_CK_PS - 1) / `DDRI_CK_PS)
`define DDRI_N_PWR    `DDRI_CEIL(`DDRI_T_PWR_US * 1000000)
`define DDRI_N_RP     `DDRI_CEIL(`DDRI_T_RP_NS * 1000)
`define DDRI_N_RFC    `DDRI_CEIL(`DDRI_T_RFC_NS * 1000)
`define DDRI_N_MRD    `DDRI_CEIL(`DDRI_T_MRD_NS * 1000)
`define DDRI_N_RAS    `DDRI_CEIL(`DDRI_T_RAS_NS * 1000)
`define DDRI_N_REFI_S (`DDRI_T_REFI_S_PS / `DDRI_CK_PS)
`define DDRI_N_REFI_L (`DDRI_T_REFI_L_PS / `DDRI_CK_PS)
`define DDRI_N_REFC_S (`DDRI_T_REFC_S_PS / `DDRI_CK_PS)
`define DDRI_N_REFC_L (`DDRI_T_REFC_L_PS / `DDRI_CK_PS)
`define DDRI_REF_GUARD 14'h0010
`define DDRI_DLL_CYC   8'hc8
`define DDRI_POST_MAX  4'h8
// ************************************************************
// pin fields
// ************************************************************
`define DDRI_LANES     8
`define DDRI_AW        13
`define DDRI_A_AP      10
`define DDRI_DLL_DIS   0
`define DDRI_DRV       1
`define DDRI_DLL_RST   8
`define DDRI_BA_MR     2'h0
`define DDRI_BA_EMR    2'h1
`endif

// >>> core/ddri_pkg.sv
package ddri_pkg;
   typedef enum logic [2:0] {
      CMD_LMR = 3'h0,
      CMD_REF = 3'h1,
      CMD_PRE = 3'h2,
      CMD_ACT = 3'h3,
      CMD_WR  = 3'h4,
      CMD_RD  = 3'h5,
      CMD_BST = 3'h6,
      CMD_NOP = 3'h7
   } ddri_cmd_t;
   typedef enum logic [3:0] {
      ST_PWR  = 4'h0,
      ST_PRE1 = 4'h1,
      ST_EMR  = 4'h3,
      ST_MRS  = 4'h2,
      ST_PRE2 = 4'h6,
      ST_REF1 = 4'h7,
      ST_REF2 = 4'h5,
      ST_MRS2 = 4'h4,
      ST_IDLE = 4'hc,
      ST_RPRE = 4'hd,
      ST_RREF = 4'hf
   } ddri_state_t;
endpackage : ddri_pkg

// >>> core/ddri_if.sv
`timescale 1ns/1ps
`include "ddri_map.svh"
interface ddri_if;
   ddri_pkg::ddri_cmd_t         cmd;
   logic [1:0]                  ba;
   logic [`DDRI_AW-1:0]         addr;
   logic                        cke;
   logic [`DDRI_LANES-1:0]      lanes;
   logic                        tick;
   modport ctrl (output cmd, output ba, output addr, output cke,
                 output lanes, input tick);
   modport link (input cmd, input ba, input addr, input cke,
                 input lanes, output tick);
endinterface : ddri_if

// >>> core/ddri_timer.sv
`timescale 1ns/1ps
`include "ddri_map.svh"
module ddri_timer (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               tick,
   input  wire logic               ld,
   input  wire logic [`DDRI_TW-1:0] val,
   output logic                    done
);
   logic [`DDRI_TW-1:0] cnt_q;
   // starts at zero so the power-up wait is loaded by the first step
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (tick) begin
         if (ld) begin
            cnt_q <= val;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - `DDRI_TW'(1);
         end
      end
   end
   assign done = (cnt_q == '0);
endmodule : ddri_timer

// >>> core/ddri_link.sv
`timescale 1ns/1ps
`include "ddri_map.svh"
module ddri_link (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   ce,
   ddri_if.link                        bus,
   output logic                        ddr_ck,
   output logic                        ddr_ck_n,
   output logic                        ddr_cke,
   output logic                        ddr_cs_n,
   output logic                        ddr_ras_n,
   output logic                        ddr_cas_n,
   output logic                        ddr_we_n,
   output logic [1:0]                  ddr_ba,
   output logic [`DDRI_AW-1:0]         ddr_addr,
   output logic [`DDRI_LANES-1:0]      ddr_dqs_oe
);
   import ddri_pkg::*;
   // ************************************************************
   // link clock: divide by two, pins change on its falling edge
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ddr_ck   <= 1'b0;
         ddr_ck_n <= 1'b1;
      end else if (ce) begin
         ddr_ck   <= ~ddr_ck;
         ddr_ck_n <= ~ddr_ck_n;
      end
   end
   assign bus.tick = ce & ddr_ck;
   // ************************************************************
   // command pins, half a link period of setup to the rising edge
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ddr_cke   <= 1'b0;
         ddr_cs_n  <= 1'b1;
         ddr_ras_n <= 1'b1;
         ddr_cas_n <= 1'b1;
         ddr_we_n  <= 1'b1;
         ddr_ba    <= '0;
         ddr_addr  <= '0;
      end else if (bus.tick) begin
         ddr_cke   <= bus.cke;
         ddr_cs_n  <= 1'b0;
         {ddr_ras_n, ddr_cas_n, ddr_we_n} <= bus.cmd;
         ddr_ba    <= bus.ba;
         ddr_addr  <= bus.addr;
      end
   end
   // ************************************************************
   // one strobe per byte lane
   // ************************************************************
   for (genvar i = 0; i < `DDRI_LANES; i++) begin : g_lane
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            ddr_dqs_oe[i] <= 1'b0;
         end else if (bus.tick) begin
            ddr_dqs_oe[i] <= (bus.cmd == CMD_WR) & bus.lanes[i]; // RQ14
         end
      end
   end
endmodule : ddri_link

// >>> tb/ddri_dram_model.sv
`timescale 1ns/1ps
module ddri_dram_model #(
   parameter int P_RFC = 5
) (
   input  wire logic        ck,
   input  wire logic        cke,
   input  wire logic        cs_n,
   input  wire logic [2:0]  cmd,
   input  wire logic [1:0]  ba,
   input  wire logic [12:0] addr,
   output logic             seen = 1'b0,
   output logic [17:0]      got,
   output logic             viol = 1'b0
);
   int rfc = 0;
   // ************************************************************
   // commands are taken on the rising link clock only
   // ************************************************************
   always @(posedge ck) begin
      seen <= !cs_n && cmd != 3'h7;
      got  <= {cmd, ba, addr};
      if (rfc > 0) rfc <= rfc - 1;
      if (!cs_n && cmd == 3'h1) rfc <= P_RFC;
      if ((rfc > 0 || (!cs_n && cmd != 3'h7)) && !cke) viol <= 1'b1;
   end
endmodule : ddri_dram_model

// >>> tb/ddr_sdram_init_refresh_sequence_tb_top.sv
`timescale 1ns/1ps
`include "ddri_map.svh"
module ddr_sdram_init_refresh_sequence_tb_top;
   import ddri_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, usr_freq_chg = 1'b0;
   logic usr_drv_reduced = 1'b0, usr_dense = 1'b0, usr_hold_ref = 1'b0;
   logic usr_valid = 1'b0, usr_ready, init_done, read_ok, seen, viol;
   logic [7:0] usr_mode = 8'h00, usr_lanes = 8'h00, ddr_dqs_oe;
   ddri_cmd_t usr_cmd = CMD_ACT;
   logic [1:0] usr_ba = 2'h0, ddr_ba;
   logic [12:0] usr_addr = 13'h0, ddr_addr;
   logic [17:0] got;
   logic [3:0] ref_owed;
   logic ddr_ck, ddr_ck_n, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
   logic [35:0] notes[$];
   int fails = 0, tests_run = 0, cyc = 0;
   time t_acc = 0, t_act = 0;
   integer seed = 32'hdd37417a;
   always #4 clk = ~clk;
   // short power-up wait keeps the run brief
   ddri_ctrl #(.P_N_PWR(14'h0014)) dut_u (.clk, .rst_n, .ce, .usr_freq_chg,
      .usr_drv_reduced, .usr_dense, .usr_mode, .usr_hold_ref, .usr_valid,
      .usr_ready, .usr_cmd, .usr_ba, .usr_addr, .usr_lanes, .init_done,
      .read_ok, .ref_owed, .ddr_ck, .ddr_ck_n, .ddr_cke, .ddr_cs_n,
      .ddr_ras_n, .ddr_cas_n, .ddr_we_n, .ddr_ba, .ddr_addr, .ddr_dqs_oe);
   ddri_dram_model mdl_u (.ck(ddr_ck), .cke(ddr_cke), .cs_n(ddr_cs_n),
      .cmd({ddr_ras_n, ddr_cas_n, ddr_we_n}), .ba(ddr_ba), .addr(ddr_addr),
      .seen, .got, .viol);
   // ************************************************************
   // notes and comparisons
   // ************************************************************
   task automatic note(input logic [2:0] c, input logic [1:0] b,
                       input logic [12:0] a, input logic [17:0] m);
      notes.push_back({m, c, b, a});
   endtask : note
   task automatic cmp_cmd(input logic [17:0] g, input logic [35:0] n);
      tests_run++;
      if ((g & n[35:18]) !== (n[17:0] & n[35:18])) begin
         fails++;
         $display("[FAIL] %0t command %h expected %h", $time, g, n[17:0]);
      end
   endtask : cmp_cmd
   task automatic cmp_bit(input logic g, input logic e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t flag %b expected %b", $time, g, e);
      end
   endtask : cmp_bit
   task automatic note_init;
      note(3'h2, 2'h0, 13'h0400, 18'h38400);
      note(3'h0, 2'h1, {11'h0, usr_drv_reduced, 1'b0}, '1);
      note(3'h0, 2'h0, {4'h0, 1'b1, usr_mode}, '1);
      note(3'h2, 2'h0, 13'h0400, 18'h38400);
      note(3'h1, 2'h0, 13'h0, 18'h38000);
      note(3'h1, 2'h0, 13'h0, 18'h38000);
      note(3'h0, 2'h0, {5'h0, usr_mode}, '1);
   endtask : note_init
   task automatic issue(input ddri_cmd_t c, input logic [12:0] a);
      @(posedge clk) #1;
      usr_cmd = c;
      usr_ba = 2'($random(seed));
      usr_addr = a;
      usr_lanes = 8'($random(seed));
      note(c, usr_ba, a, '1);
      usr_valid = 1'b1;
      do @(negedge clk); while (usr_ready !== 1'b1);
      @(posedge clk) t_acc = $time;
      #1 usr_valid = 1'b0;
   endtask : issue
   task automatic conclude;
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   // ************************************************************
   // watcher and timeout
   // ************************************************************
   always @(negedge ddr_ck) begin
      if (seen === 1'b1 && notes.size() == 0) begin
         fails++;
         $display("[FAIL] %0t unexpected command %h", $time, got);
      end else if (seen === 1'b1) begin
         cmp_cmd(got, notes.pop_front());
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         fails++;
         conclude();
      end
   end
   // ************************************************************
   // stimulus
   // ************************************************************
   initial begin
      usr_drv_reduced = 1'($random(seed));
      usr_mode = 8'($random(seed));
      note_init();
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      while (init_done !== 1'b1) @(posedge clk) #1;
      cmp_bit(read_ok, 1'b0);
      issue(CMD_ACT, 13'($random(seed)));
      repeat (10) @(posedge clk);
      #1 usr_freq_chg = 1'b1;
      @(posedge clk) #1 usr_freq_chg = 1'b0;
      note_init();
      while (init_done !== 1'b0) @(posedge clk) #1;
      while (init_done !== 1'b1) @(posedge clk) #1;
      repeat (420) @(posedge clk);
      #1 cmp_bit(read_ok, 1'b1);
      issue(CMD_ACT, 13'($random(seed)));
      t_act = t_acc;
      issue(CMD_RD, 13'h0000);
      issue(CMD_WR, 13'h0400);
      cmp_bit(t_acc - t_act >= `DDRI_T_RAS_NS, 1'b1);
      @(posedge ddr_ck iff {ddr_ras_n, ddr_cas_n, ddr_we_n} == CMD_WR);
      cmp_bit(ddr_dqs_oe === usr_lanes, 1'b1);
      note(3'h2, 2'h0, 13'h0400, 18'h38400);
      note(3'h1, 2'h0, 13'h0, 18'h38000);
      repeat (2200) @(posedge clk);
      cmp_bit(notes.size() == 0, 1'b1);
      cmp_bit(viol, 1'b0);
      cmp_bit(ref_owed === 4'h0, 1'b1);
      conclude();
   end
endmodule : ddr_sdram_init_refresh_sequence_tb_top
